// ### src/rcl_clock_ctrl.sv
// receive clock and lock-source control for four channels, with Avalon-MM registers
// assumes pins arrive asynchronously; clk stands in for the reference clock
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.svh"

module rcl_clock_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// device pins, asynchronous
	input wire logic devResetN,
	input wire logic detectorGateEnable,
	input wire logic [3:0] forceLocalClockN,
	input wire logic [3:0] rangeOk,
	input wire logic [7:0] levelCode,
	input wire logic [3:0] serialBit,
	// receive clock outputs and status
	output logic [3:0] receiveClockOutP,
	output logic [3:0] receiveClockOutN,
	output logic [3:0] receivePllOnRef,
	output logic [3:0] linkFaultOutN,
	output logic irq
);

	// =====================================================================
	// pin synchronisers
	logic [`RCL_PIN_W-1:0] pinRaw;
	logic [`RCL_PIN_W-1:0] pinS1_ff;
	logic [`RCL_PIN_W-1:0] pinS2_ff;
	logic [`RCL_PIN_W-1:0] pinS3_ff;
	logic [`RCL_PIN_W-1:0] pin_ff;
	logic [`RCL_PIN_W-1:0] nxt_pin;

	assign pinRaw = {serialBit, levelCode, rangeOk, forceLocalClockN, detectorGateEnable, devResetN};

	// a bit changes only once the second and third stages agree
	always_comb begin
		nxt_pin = (pinS2_ff & pinS3_ff) | (pin_ff & (pinS2_ff ^ pinS3_ff));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pinS1_ff <= '0;
			pinS2_ff <= '0;
			pinS3_ff <= '0;
			pin_ff <= '0;
		end else begin
			pinS1_ff <= pinRaw;
			pinS2_ff <= pinS1_ff;
			pinS3_ff <= pinS2_ff;
			pin_ff <= nxt_pin;
		end
	end

	logic devHeld;
	logic clr;
	logic detEn;
	logic [3:0] ulcN;
	logic [3:0] rangeGood;
	logic [7:0] level;

	assign devHeld = ~pin_ff[`RCL_PIN_DEVRST];
	// device reset only clears this block; the bus handshake registers use rst alone
	assign clr = rst | devHeld;
	assign detEn = pin_ff[`RCL_PIN_DETEN];
	assign ulcN = pin_ff[`RCL_PIN_ULC +: 4];
	assign rangeGood = pin_ff[`RCL_PIN_RANGE +: 4];
	assign level = pin_ff[`RCL_PIN_LEVEL +: 8];

	// =====================================================================
	// transition density detector
	rcl_det_if detBus();
	assign detBus.serBit = pin_ff[`RCL_PIN_SER +: 4];
	assign detBus.clear = devHeld;

	rcl_density_det u_dens (
		.clk(clk),
		.rst(rst),
		.det(detBus.det)
	);

	// =====================================================================
	// registers and bus slave
	logic [3:0] rate_ff, cksel_ff, half_ff, mask_ff, irqStat_ff;
	logic [7:0] trip_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [3:0] nxt_rate, nxt_cksel, nxt_half, nxt_mask, nxt_irqStat;
	logic [7:0] nxt_trip;
	logic nxt_ack;
	logic [31:0] nxt_rdata;
	logic [3:0] fault_ff, onRef_ff;
	logic [3:0] faultNow, onRefNow, faultRise;
	logic [3:0] levelGood;

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
		hit = (addr == off);
	endfunction

	logic wrDone;
	// one wait cycle per access keeps the read data registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign wrDone = avs_write & ack_ff;
	assign avs_readdata = rdata_ff;

	always_comb begin
		nxt_ack = (avs_read | avs_write) & ~ack_ff;
		nxt_rate = rate_ff;
		nxt_cksel = cksel_ff;
		nxt_half = half_ff;
		nxt_trip = trip_ff;
		nxt_mask = mask_ff;
		nxt_rdata = rdata_ff;
		// a new fault wins over a clear in the same cycle
		nxt_irqStat = irqStat_ff;
		if (wrDone && hit(avs_address, `RCL_OFF_CLKCFG)) begin
			nxt_rate = avs_writedata[`RCL_CFG_RATE_LSB +: 4];
			nxt_cksel = avs_writedata[`RCL_CFG_CKSEL_LSB +: 4];
			nxt_half = avs_writedata[`RCL_CFG_HALF_LSB +: 4];
		end
		if (wrDone && hit(avs_address, `RCL_OFF_TRIP))
			nxt_trip = avs_writedata[7:0];
		if (wrDone && hit(avs_address, `RCL_OFF_IRQMASK))
			nxt_mask = avs_writedata[3:0];
		if (wrDone && hit(avs_address, `RCL_OFF_IRQSTAT))
			nxt_irqStat = irqStat_ff & ~avs_writedata[3:0];
		nxt_irqStat = nxt_irqStat | faultRise;
		if (avs_read & ~ack_ff) begin
			nxt_rdata = 32'h0000_0000;
			if (hit(avs_address, `RCL_OFF_CLKCFG)) begin
				nxt_rdata[`RCL_CFG_RATE_LSB +: 4] = rate_ff;
				nxt_rdata[`RCL_CFG_CKSEL_LSB +: 4] = cksel_ff;
				nxt_rdata[`RCL_CFG_HALF_LSB +: 4] = half_ff;
			end
			if (hit(avs_address, `RCL_OFF_TRIP))
				nxt_rdata[7:0] = trip_ff;
			if (hit(avs_address, `RCL_OFF_STATUS)) begin
				nxt_rdata[`RCL_ST_ONREF_LSB +: 4] = onRef_ff;
				nxt_rdata[`RCL_ST_FAULT_LSB +: 4] = fault_ff;
				nxt_rdata[`RCL_ST_STARVE_LSB +: 4] = detBus.starved;
			end
			if (hit(avs_address, `RCL_OFF_IRQSTAT))
				nxt_rdata[3:0] = irqStat_ff;
			if (hit(avs_address, `RCL_OFF_IRQMASK))
				nxt_rdata[3:0] = mask_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (clr) begin
			rate_ff <= `RCL_RST_RATE;
			cksel_ff <= `RCL_RST_CKSEL;
			half_ff <= `RCL_RST_HALF;
			trip_ff <= `RCL_RST_TRIP;
			mask_ff <= `RCL_RST_MASK;
			irqStat_ff <= 4'h0;
		end else begin
			rate_ff <= nxt_rate;
			cksel_ff <= nxt_cksel;
			half_ff <= nxt_half;
			trip_ff <= nxt_trip;
			mask_ff <= nxt_mask;
			irqStat_ff <= nxt_irqStat;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	assign irq = |(irqStat_ff & mask_ff);

	// =====================================================================
	// lock source and link fault
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			levelGood[i] = level[2*i +: 2] >= trip_ff[2*i +: 2];
			// gate high: all three detectors vote; gate low: range alone
			onRefNow[i] = ~ulcN[i] | ~rangeGood[i] |
				(detEn & (~levelGood[i] | detBus.starved[i]));
			faultNow[i] = ~ulcN[i] | ~rangeGood[i] | ~levelGood[i] | detBus.starved[i];
		end
		faultRise = faultNow & ~fault_ff;
	end

	always_ff @(posedge clk) begin
		if (clr) begin
			fault_ff <= 4'h0;
			onRef_ff <= 4'h0;
		end else begin
			fault_ff <= faultNow;
			onRef_ff <= onRefNow;
		end
	end

	assign receivePllOnRef = onRef_ff;
	assign linkFaultOutN = ~fault_ff;

	// =====================================================================
	// receive clock outputs
	genvar gc;
	generate
		for (gc = 0; gc < 4; gc++) begin : g_clk
			rcl_pkg::rcl_rate_t rateNow, rateCode_ff;
			logic phase_ff, wave_ff;
			logic nxt_phase, nxt_wave;

			always_comb begin
				if (half_ff[gc] && cksel_ff[gc])
					rateNow = rcl_pkg::RC_REF;
				else if (rate_ff[gc])
					rateNow = rcl_pkg::RC_CHAR;
				else
					rateNow = rcl_pkg::RC_DUAL;
				nxt_phase = ~phase_ff;
				// runs without a stop in every mode; dual rate toggles half as often
				case (rateCode_ff)
					rcl_pkg::RC_DUAL: nxt_wave = phase_ff ? ~wave_ff : wave_ff;
					rcl_pkg::RC_CHAR: nxt_wave = ~wave_ff;
					rcl_pkg::RC_REF: nxt_wave = ~wave_ff;
					default: nxt_wave = ~wave_ff;
				endcase
			end

			// the extra register stage is the phase delay toward the data
			always_ff @(posedge clk) begin
				if (clr) begin
					rateCode_ff <= rcl_pkg::RC_DUAL;
					// phase high first: the first edge after reset toggles, no three-cycle stall
					phase_ff <= 1'b1;
					wave_ff <= 1'b0;
				end else begin
					rateCode_ff <= rateNow;
					phase_ff <= nxt_phase;
					wave_ff <= nxt_wave;
				end
			end

			assign receiveClockOutP[gc] = wave_ff;
			assign receiveClockOutN[gc] = ~wave_ff;

			a_rate_ref: assert property (@(posedge clk) disable iff (clr)
				(half_ff[gc] && cksel_ff[gc]) |=> (rateCode_ff == rcl_pkg::RC_REF))
				else $error("half reference with source 1 not at reference rate");

			a_rate_follow: assert property (@(posedge clk) disable iff (clr)
				!(half_ff[gc] && cksel_ff[gc]) |=>
				(rateCode_ff == ($past(rate_ff[gc]) ? rcl_pkg::RC_CHAR : rcl_pkg::RC_DUAL)))
				else $error("receive clock rate ignores the rate select");

			a_clock_runs: assert property (@(posedge clk) disable iff (clr)
				(wave_ff == $past(wave_ff)) |=> (wave_ff != $past(wave_ff)))
				else $error("receive clock stalled for more than two cycles");
		end
	endgenerate

	// =====================================================================
	// checks
	a_ulc_fault: assert property (@(posedge clk) disable iff (clr)
		!ulcN[0] |=> !linkFaultOutN[0] && receivePllOnRef[0])
		else $error("local clock forced but no fault or no reference lock");

	a_gate_starved: assert property (@(posedge clk) disable iff (clr)
		(detEn && detBus.starved[3]) |=> receivePllOnRef[3])
		else $error("starved stream did not move pll to reference");

	a_range_only: assert property (@(posedge clk) disable iff (clr)
		(!detEn && ulcN[2] && rangeGood[2]) |=> !receivePllOnRef[2])
		else $error("gate low but a detector other than range took effect");

	a_bus_wait: assert property (@(posedge clk) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access waited more than one cycle");

	a_irq_set: assert property (@(posedge clk) disable iff (clr)
		$fell(linkFaultOutN[3]) |-> irqStat_ff[3] ##1 irqStat_ff[3] || !$past(wrDone))
		else $error("link fault did not set its status bit");

	a_dev_reset: assert property (@(posedge clk) disable iff (rst)
		devHeld |=> (rate_ff == `RCL_RST_RATE) && (cksel_ff == `RCL_RST_CKSEL)
		&& (linkFaultOutN == 4'hf))
		else $error("device reset left configuration or fault state set");

endmodule

`default_nettype wire

// ### src/rcl_density_det.sv
// transition density detector for four channels
// assumes serBit already synchronised, one serial bit sample per clock
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.svh"

module rcl_density_det (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// detector side
	rcl_det_if.det det
);

	// =====================================================================
	// per-channel run counter
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			logic lastBit_ff;
			logic [5:0] runCnt_ff;
			rcl_pkg::rcl_dens_t state_ff;
			logic nxt_lastBit;
			logic [5:0] nxt_runCnt;
			rcl_pkg::rcl_dens_t nxt_state;

			always_comb begin
				nxt_lastBit = det.serBit[gi];
				nxt_runCnt = runCnt_ff;
				nxt_state = state_ff;
				if (det.clear) begin
					nxt_runCnt = 6'h00;
					nxt_state = rcl_pkg::DS_TRACK;
				end else if (det.serBit[gi] != lastBit_ff) begin
					nxt_runCnt = 6'h00;
					nxt_state = rcl_pkg::DS_TRACK;
				end else begin
					case (state_ff)
						rcl_pkg::DS_TRACK: begin
							// sixty bits with no transition trips the detector
							if (runCnt_ff == `RCL_DENS_LIMIT - 6'h01)
								nxt_state = rcl_pkg::DS_STARVED;
							else
								nxt_runCnt = runCnt_ff + 6'h01;
						end
						rcl_pkg::DS_STARVED: nxt_state = rcl_pkg::DS_STARVED;
						default: nxt_state = rcl_pkg::DS_TRACK;
					endcase
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					lastBit_ff <= 1'b0;
					runCnt_ff <= 6'h00;
					state_ff <= rcl_pkg::DS_TRACK;
				end else begin
					lastBit_ff <= nxt_lastBit;
					runCnt_ff <= nxt_runCnt;
					state_ff <= nxt_state;
				end
			end

			assign det.starved[gi] = (state_ff == rcl_pkg::DS_STARVED);

			a_starve_clear: assert property (@(posedge clk) disable iff (rst)
				(det.serBit[gi] != lastBit_ff) |=> !det.starved[gi])
				else $error("detector stayed starved after a transition");
		end
	endgenerate

	// helper: consecutive samples of channel 3 without a change
	// the previous bit follows the stream through a clear, as the detector's does
	logic [6:0] quiet_ff;
	logic prevBit_ff;
	always_ff @(posedge clk) begin
		if (rst) begin
			quiet_ff <= 7'h00;
			prevBit_ff <= 1'b0;
		end else begin
			prevBit_ff <= det.serBit[3];
			if (det.clear || (det.serBit[3] != prevBit_ff))
				quiet_ff <= 7'h00;
			else if (quiet_ff != 7'h7f)
				quiet_ff <= quiet_ff + 7'h01;
		end
	end

	a_starve_after60: assert property (@(posedge clk) disable iff (rst)
		(quiet_ff == 7'h3d) |-> det.starved[3])
		else $error("sixty quiet bits did not trip the detector");

	a_starve_early: assert property (@(posedge clk) disable iff (rst)
		$rose(det.starved[3]) |-> (quiet_ff == 7'h3c))
		else $error("detector tripped before sixty quiet bits");

endmodule

`default_nettype wire

// ### src/rcl_det_if.sv
// carrier between the clock control and its transition density detector
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface rcl_det_if;
	logic [3:0] serBit;
	logic clear;
	logic [3:0] starved;

	modport ctl(output serBit, output clear, input starved);
	modport det(input serBit, input clear, output starved);
endinterface

`default_nettype wire

// ### src/rcl_pkg.sv
// types shared by the receive clock control modules
// assumes nothing beyond the compiler
package rcl_pkg;

	// rate of a receive clock output: dual-character, character or reference rate
	typedef enum logic [1:0] {RC_DUAL, RC_CHAR, RC_REF} rcl_rate_t;

	// transition density detector state
	typedef enum logic {DS_TRACK, DS_STARVED} rcl_dens_t;

endpackage

// ### src/rcl_regs.svh
// register offsets, field positions, reset values and counts of the receive clock control
// assumes byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
`ifndef RCL_REGS_SVH
`define RCL_REGS_SVH

// =====================================================================
// register offsets
`define RCL_OFF_CLKCFG 5'h00
`define RCL_OFF_TRIP 5'h04
`define RCL_OFF_STATUS 5'h08
`define RCL_OFF_IRQSTAT 5'h0c
`define RCL_OFF_IRQMASK 5'h10

// =====================================================================
// field positions of the clock configuration register
`define RCL_CFG_RATE_LSB 0
`define RCL_CFG_CKSEL_LSB 4
`define RCL_CFG_HALF_LSB 8

// field positions of the status register
`define RCL_ST_ONREF_LSB 0
`define RCL_ST_FAULT_LSB 4
`define RCL_ST_STARVE_LSB 8

// =====================================================================
// reset values
`define RCL_RST_RATE 4'h0
`define RCL_RST_CKSEL 4'h0
`define RCL_RST_HALF 4'h0
`define RCL_RST_TRIP 8'h00
`define RCL_RST_MASK 4'h0

// =====================================================================
// pin vector layout, after the three-stage synchronisers
`define RCL_PIN_W 22
`define RCL_PIN_DEVRST 0
`define RCL_PIN_DETEN 1
`define RCL_PIN_ULC 2
`define RCL_PIN_RANGE 6
`define RCL_PIN_LEVEL 10
`define RCL_PIN_SER 18

// =====================================================================
// timing counts
`define RCL_DENS_LIMIT 6'h3c

`endif

// ### tb/rcl_host_model.sv
// system logic that drives the static control pins of the receive clock control
// assumes the bench calls its tasks; pins change just after a rising edge
`timescale 1ns/1ps
`default_nettype none

module rcl_host_model (
	// clock
	input wire logic clk,
	// control pins toward the device
	output var logic devResetN,
	output var logic detectorGateEnable,
	output var logic [3:0] forceLocalClockN,
	output var logic [3:0] rangeOk,
	output var logic [7:0] levelCode,
	output var logic [3:0] serialBit
);
	logic [3:0] holdMask;
	logic serPhase;

	// =====================================================================
	// quiet start: all detectors in limits, gate high for recovered clock
	initial begin
		devResetN = 1'b1;
		detectorGateEnable = 1'b1;
		forceLocalClockN = 4'hf;
		rangeOk = 4'hf;
		levelCode = 8'hff;
		serialBit = 4'h5;
		holdMask = 4'h0;
		serPhase = 1'b0;
	end

	// =====================================================================
	// serial stream changes every second clock unless a channel is held stuck;
	// the pin filter drops one-clock pulses, so a bit must stand two clocks
	always @(posedge clk) begin
		serPhase <= ~serPhase;
		if (serPhase)
			serialBit <= serialBit ^ ~holdMask;
	end

	task automatic drive(input logic gate, input logic [3:0] ulcN, input logic [3:0] range,
		input logic [7:0] level);
		@(posedge clk);
		detectorGateEnable <= gate;
		forceLocalClockN <= ulcN;
		rangeOk <= range;
		levelCode <= level;
	endtask

	task automatic hold(input logic [3:0] mask);
		@(posedge clk);
		holdMask <= mask;
	endtask

	// low for the given number of clocks; at two or more it is not filtered as a glitch
	task automatic pulse_reset(input int cycles);
		@(posedge clk);
		devResetN <= 1'b0;
		repeat (cycles) @(posedge clk);
		devResetN <= 1'b1;
	endtask
endmodule

`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the receive clock control
// assumes the host model drives the pins; registers reached over avalon-mm
`timescale 1ns/1ps
`default_nettype none
`include "rcl_regs.svh"

module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avsAddress = 5'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWritedata = 32'h0;
	logic [31:0] avsReaddata;
	logic avsWaitrequest;
	logic devResetN, detectorGateEnable, irq;
	logic [3:0] forceLocalClockN, rangeOk, serialBit;
	logic [7:0] levelCode;
	logic [3:0] clkP, clkN, pllOnRef, faultN;
	int errors = 0;
	int checks_done = 0;

	always #4 clk = ~clk;

	rcl_clock_ctrl u_dut (.clk(clk), .rst(rst), .avs_address(avsAddress), .avs_read(avsRead),
		.avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
		.avs_waitrequest(avsWaitrequest), .devResetN(devResetN),
		.detectorGateEnable(detectorGateEnable), .forceLocalClockN(forceLocalClockN),
		.rangeOk(rangeOk), .levelCode(levelCode), .serialBit(serialBit),
		.receiveClockOutP(clkP), .receiveClockOutN(clkN), .receivePllOnRef(pllOnRef),
		.linkFaultOutN(faultN), .irq(irq));

	rcl_host_model u_host (.clk(clk), .devResetN(devResetN),
		.detectorGateEnable(detectorGateEnable), .forceLocalClockN(forceLocalClockN),
		.rangeOk(rangeOk), .levelCode(levelCode), .serialBit(serialBit));

	// =====================================================================
	// checking and closing
	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// =====================================================================
	// bus cycles: request held until waitrequest is seen low at a rising edge
	task automatic bus_access(input logic wr, input logic [4:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		int n;
		n = 0;
		@(posedge clk);
		avsAddress <= addr;
		avsWrite <= wr;
		avsRead <= ~wr;
		avsWritedata <= wdata;
		// waitrequest and read data are both taken at the completing rising edge
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 20);
		if (avsWaitrequest !== 1'b0) begin
			errors++;
			$display("FAIL at %0t: bus wait ran out", $time);
			final_report();
		end
		rdata = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask

	task automatic bus_write(input logic [4:0] addr, input logic [31:0] wdata);
		logic [31:0] unused;
		bus_access(1'b1, addr, wdata, unused);
	endtask

	task automatic bus_read_check(input logic [4:0] addr, input logic [31:0] exp);
		logic [31:0] got;
		bus_access(1'b0, addr, 32'h0, got);
		check(got, exp);
	endtask

	// pin changes need about five clocks through the synchronisers
	task automatic settle(input int cycles);
		repeat (cycles) @(posedge clk);
		@(negedge clk);
	endtask

	// toggles of each P output over 16 clocks: 8 at dual-character rate, 16 otherwise
	task automatic measure_rate(input logic [3:0] dualCh);
		int cnt[4];
		logic [3:0] last;
		cnt = '{0, 0, 0, 0};
		settle(4);
		last = clkP;
		repeat (16) begin
			@(negedge clk);
			check({28'h0, clkN}, {28'h0, ~clkP});
			for (int i = 0; i < 4; i++) begin
				if (clkP[i] !== last[i]) cnt[i]++;
			end
			last = clkP;
		end
		for (int i = 0; i < 4; i++) begin
			check(32'(cnt[i]), dualCh[i] ? 32'd8 : 32'd16);
		end
	endtask

	// =====================================================================
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		bus_read_check(`RCL_OFF_CLKCFG, 32'h0);
		bus_read_check(`RCL_OFF_TRIP, 32'h0);
		bus_read_check(`RCL_OFF_STATUS, 32'h0);
		bus_read_check(`RCL_OFF_IRQSTAT, 32'h0);
		bus_read_check(`RCL_OFF_IRQMASK, 32'h0);
		bus_write(5'h14, 32'hffffffff);
		bus_read_check(5'h14, 32'h0);
		measure_rate(4'hf);
		// per channel: rate 0101, source 1100, half-rate reference 1010
		bus_write(`RCL_OFF_CLKCFG, 32'h00000ac5);
		bus_read_check(`RCL_OFF_CLKCFG, 32'h00000ac5);
		measure_rate(4'h2);
		// forced local clock on channel 0, interrupt masked then unmasked
		u_host.drive(1'b1, 4'he, 4'hf, 8'hff);
		settle(12);
		check({28'h0, faultN}, 32'he);
		check({28'h0, pllOnRef}, 32'h1);
		check({31'h0, irq}, 32'h0);
		bus_read_check(`RCL_OFF_STATUS, 32'h011);
		bus_read_check(`RCL_OFF_IRQSTAT, 32'h1);
		bus_write(`RCL_OFF_IRQMASK, 32'h1);
		settle(0);
		check({31'h0, irq}, 32'h1);
		u_host.drive(1'b1, 4'hf, 4'hf, 8'hff);
		settle(12);
		check({28'h0, pllOnRef}, 32'h0);
		check({31'h0, irq}, 32'h1);
		bus_write(`RCL_OFF_IRQSTAT, 32'h1);
		settle(0);
		check({31'h0, irq}, 32'h0);
		// ch1 out of range, ch2 below trip 3; gate low then high
		bus_write(`RCL_OFF_TRIP, 32'h30);
		u_host.drive(1'b0, 4'hf, 4'hd, 8'hdf);
		settle(12);
		check({28'h0, pllOnRef}, 32'h2);
		u_host.drive(1'b1, 4'hf, 4'hd, 8'hdf);
		settle(12);
		check({28'h0, pllOnRef}, 32'h6);
		u_host.drive(1'b1, 4'hf, 4'hf, 8'hff);
		settle(12);
		check({28'h0, pllOnRef}, 32'h0);
		// ch3 stuck: no starvation before 60 bits, starvation well after
		u_host.hold(4'h8);
		settle(40);
		check({28'h0, pllOnRef}, 32'h0);
		settle(40);
		bus_read_check(`RCL_OFF_STATUS, 32'h888);
		u_host.hold(4'h0);
		settle(12);
		check({28'h0, pllOnRef}, 32'h0);
		// device reset pin clears configuration and sticky state
		u_host.pulse_reset(8);
		settle(12);
		bus_read_check(`RCL_OFF_CLKCFG, 32'h0);
		bus_read_check(`RCL_OFF_TRIP, 32'h0);
		bus_read_check(`RCL_OFF_IRQSTAT, 32'h0);
		bus_read_check(`RCL_OFF_IRQMASK, 32'h0);
		final_report();
	end
endmodule

`default_nettype wire
